/* logic/tgc_params.svh */
// constants for the global timer start/reload/stop command block
// assumes an 8-bit special-function register port with a page number
`ifndef TGC_PARAMS_SVH
`define TGC_PARAMS_SVH
`define START_CMD_ADDR 8'h95
`define RELOAD_CMD_ADDR 8'h95
`define STOP_CMD_ADDR 8'h95
`define START_CMD_PAGE 4'h1
`define RELOAD_CMD_PAGE 4'h2
`define STOP_CMD_PAGE 4'h3
`define STATUS_ADDR 8'h96
`define STATUS_PAGE 4'h1
`define CMD_RESET 8'h00
`define BIT_T0 0
`define BIT_T1 1
`define BIT_T2 2
`define BIT_T3 3
`define BIT_T2_LOW 5
`define BIT_T3_LOW 6
`define CMD_USED_MASK 8'h6f
`endif

/* logic/tgc_pkg.sv */
// types for the global timer start/reload/stop command block
// assumes nothing beyond the params header
package tgc_pkg;
  typedef struct packed {
    logic run_t3_low_half;
    logic run_t2_low_half;
    logic run_t3;
    logic run_t2;
    logic run_t1;
    logic run_t0;
  } run_bits_t;
  typedef struct packed {
    logic t3_low;
    logic t2_low;
    logic t3;
    logic t2;
    logic t1;
    logic t0;
  } reload_bits_t;
  typedef struct packed {
    logic split_t2;
    logic split_t3;
    logic capture_t2;
    logic capture_t3;
  } timer_mode_t;
  typedef enum logic [1:0] {
    CMD_NONE = 2'b00,
    CMD_START = 2'b01,
    CMD_RELOAD = 2'b10,
    CMD_STOP = 2'b11
  } cmd_kind_t;
endpackage

/* logic/tgc_decode.sv */
// register port decode: which command register a write hits
// assumes single-cycle strobes from the bus master
`timescale 1ns/1ns
`include "tgc_params.svh"
module tgc_decode
  import tgc_pkg::*;
(
  input wire logic [7:0] addr,
  input wire logic [3:0] page,
  input wire logic wr_en,
  output cmd_kind_t kind
);
  // pages keep the three registers apart at one address
  always_comb begin
    kind = CMD_NONE;
    if (wr_en && addr == `START_CMD_ADDR && page == `START_CMD_PAGE) begin
      kind = CMD_START;
    end else if (wr_en && addr == `RELOAD_CMD_ADDR && page == `RELOAD_CMD_PAGE) begin
      kind = CMD_RELOAD;
    end else if (wr_en && addr == `STOP_CMD_ADDR && page == `STOP_CMD_PAGE) begin
      kind = CMD_STOP;
    end
  end
endmodule // tgc_decode

/* logic/tgc_reload_gate.sv */
// gates forced reload requests by split and capture mode
// assumes mode inputs are levels from the timer cores
`timescale 1ns/1ns
`include "tgc_params.svh"
module tgc_reload_gate
  import tgc_pkg::*;
(
  input wire logic [7:0] wdata,
  input timer_mode_t mode,
  output reload_bits_t req
);
  always_comb begin
    req.t0 = wdata[`BIT_T0];
    req.t1 = wdata[`BIT_T1];
    // capture mode blocks both halves; split case only hits high byte downstream
    req.t2 = wdata[`BIT_T2] & ~mode.capture_t2;
    req.t3 = wdata[`BIT_T3] & ~mode.capture_t3;
    req.t2_low = wdata[`BIT_T2_LOW] & mode.split_t2 & ~mode.capture_t2;
    req.t3_low = wdata[`BIT_T3_LOW] & mode.split_t3 & ~mode.capture_t3;
  end
endmodule // tgc_reload_gate

/* logic/timer_global_run_control.sv */
// global start/reload/stop control for timers 0-3
// assumes a simple register port and timer cores that take run levels
// and one-cycle reload strobes on the same clock
//
// The strobed register port was decided locally.
`timescale 1ns/1ns
`include "tgc_params.svh"
// How it works
// - a one in start bits 0-3 sets the run bit of timer 0-3.
// - a one in start bit 6 or 5 sets the low-half run bit of timer 3 or 2 in split mode.
// - every command bit is a pulse that clears itself after the write.
// - a zero written to a command bit does nothing.
// - the start register sits at 0x95 on page 1 and resets to zero.
// - reload bits 0 and 1 force a full reload of timer 0 or 1.
// - reload bits 3 and 2 reload both bytes of timer 3 or 2, only the high byte if split.
// - forced reloads of timer 2 or 3 are dropped while it captures.
// - reload bits 6 and 5 reload the low byte of timer 3 or 2 in split mode.
// - a one in stop bits 0-3 clears the run bit of timer 0-3.
// - a one in stop bit 6 or 5 clears the low-half run bit of timer 3 or 2 in split mode.
// - all timers started by one write begin on the same cycle.
module timer_global_run_control
  import tgc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [3:0] page,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  input timer_mode_t mode,
  input run_bits_t run_sw_set,
  input run_bits_t run_sw_clr,
  output run_bits_t run,
  output reload_bits_t reload_strobe
);
  typedef struct packed {
    run_bits_t run;
    reload_bits_t reload;
    logic [7:0] rdata;
  } state_t;

  state_t state_ff;
  state_t nxt_state;
  cmd_kind_t kind;
  reload_bits_t reload_req;

  tgc_decode u_decode (
    .addr(addr),
    .page(page),
    .wr_en(wr_en),
    .kind(kind)
  );

  tgc_reload_gate u_reload_gate (
    .wdata(wdata),
    .mode(mode),
    .req(reload_req)
  );

  // one bit of run state: clear wins over set; command and software levels are ORed
  function automatic logic run_next(input logic cur, input logic set, input logic clr);
    run_next = (cur | set) & ~clr;
  endfunction

  // command bits are never stored, so they read back as zero
  always_comb begin
    logic [7:0] sw;
    logic [7:0] st;
    logic [7:0] sp;
    sw = 8'h00;
    st = 8'h00;
    sp = 8'h00;
    nxt_state = state_ff;
    nxt_state.reload = '0;
    if (kind == CMD_START) begin
      st = wdata & `CMD_USED_MASK;
    end
    if (kind == CMD_STOP) begin
      sp = wdata & `CMD_USED_MASK;
    end
    if (kind == CMD_RELOAD) begin
      nxt_state.reload = reload_req;
    end
    // all timers move together on the same edge
    nxt_state.run.run_t0 = run_next(state_ff.run.run_t0,
      st[`BIT_T0] | run_sw_set.run_t0, sp[`BIT_T0] | run_sw_clr.run_t0);
    nxt_state.run.run_t1 = run_next(state_ff.run.run_t1,
      st[`BIT_T1] | run_sw_set.run_t1, sp[`BIT_T1] | run_sw_clr.run_t1);
    nxt_state.run.run_t2 = run_next(state_ff.run.run_t2,
      st[`BIT_T2] | run_sw_set.run_t2, sp[`BIT_T2] | run_sw_clr.run_t2);
    nxt_state.run.run_t3 = run_next(state_ff.run.run_t3,
      st[`BIT_T3] | run_sw_set.run_t3, sp[`BIT_T3] | run_sw_clr.run_t3);
    nxt_state.run.run_t2_low_half = run_next(state_ff.run.run_t2_low_half,
      (st[`BIT_T2_LOW] & mode.split_t2) | run_sw_set.run_t2_low_half,
      (sp[`BIT_T2_LOW] & mode.split_t2) | run_sw_clr.run_t2_low_half);
    nxt_state.run.run_t3_low_half = run_next(state_ff.run.run_t3_low_half,
      (st[`BIT_T3_LOW] & mode.split_t3) | run_sw_set.run_t3_low_half,
      (sp[`BIT_T3_LOW] & mode.split_t3) | run_sw_clr.run_t3_low_half);
    // read path: command registers read zero, status shows run bits
    if (rd_en && addr == `STATUS_ADDR && page == `STATUS_PAGE) begin
      sw = {1'b0, state_ff.run.run_t3_low_half, state_ff.run.run_t2_low_half, 1'b0,
        state_ff.run.run_t3, state_ff.run.run_t2, state_ff.run.run_t1, state_ff.run.run_t0};
    end
    nxt_state.rdata = sw;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign run = state_ff.run;
  assign reload_strobe = state_ff.reload;
  assign rdata = state_ff.rdata;
endmodule // timer_global_run_control

/* testbench/tgc_chk.sv */
// checker: command timing at the timer control ports
// assumes a bind onto timer_global_run_control
`timescale 1ns/1ns
module tgc_chk
  import tgc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [3:0] page,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rdata,
  input timer_mode_t mode,
  input run_bits_t run_sw_set,
  input run_bits_t run_sw_clr,
  input run_bits_t run,
  input reload_bits_t reload_strobe
);
  // page picks the register; sw levels would mask command effects
  wire hit = wr_en && addr == 8'h95;
  wire st = hit && page == 4'h1;
  wire rl = hit && page == 4'h2;
  wire sp = hit && page == 4'h3;
  wire sw0 = run_sw_set == 6'h00 && run_sw_clr == 6'h00;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_start_run: assert property (
    st && sw0 |=> run[3:0] == ($past(run[3:0]) | $past(wdata[3:0]))) else $error("start");
  a_start_low: assert property (
    st && sw0 && mode.split_t3 && wdata[6] |=> run.run_t3_low_half) else $error("start low");
  a_low_nosplit: assert property (
    (st || sp) && sw0 && !mode.split_t2 |=> $stable(run.run_t2_low_half)) else $error("nosplit");
  a_stop_run: assert property (
    sp && sw0 |=> run[3:0] == ($past(run[3:0]) & ~$past(wdata[3:0]))) else $error("stop");
  a_reload_page: assert property (
    rl && sw0 |=> $stable(run)) else $error("reload page");
  a_reload_t0: assert property (
    rl && wdata[0] |=> reload_strobe.t0) else $error("reload t0");
  a_capture_drop: assert property (
    rl && mode.capture_t3 |=> !reload_strobe.t3) else $error("capture");
  a_strobe_cause: assert property (
    reload_strobe.t1 |-> $past(rl) && $past(wdata[1])) else $error("strobe");
  a_cmd_reads0: assert property (
    rd_en && addr == 8'h95 |=> rdata == 8'h00) else $error("readback");
endmodule // tgc_chk
bind timer_global_run_control tgc_chk chk (.clk, .rst_n, .addr, .page, .wdata, .wr_en,
  .rd_en, .rdata, .mode, .run_sw_set, .run_sw_clr, .run, .reload_strobe);

/* testbench/testbench.sv */
// bench: command writes and reads with expected run and reload values
// assumes the design and the bound checker are compiled first
`timescale 1ns/1ns
module testbench;
  import tgc_pkg::*;
  logic clk = 0, rst_n = 0, wr_en = 0, rd_en = 0;
  logic [7:0] addr = 0, wdata = 0, rdata;
  logic [3:0] page = 0;
  timer_mode_t mode = '0;
  run_bits_t run_sw_set = '0, run_sw_clr = '0, run;
  reload_bits_t reload_strobe;
  int miscompares = 0, tests_run = 0;
  timer_global_run_control dut (.clk, .rst_n, .addr, .page, .wdata, .wr_en,
    .rd_en, .rdata, .mode, .run_sw_set, .run_sw_clr, .run, .reload_strobe);
  always #5 clk = ~clk;
  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  // one strobe cycle; results land after the taking edge
  task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] p, input logic [7:0] d);
    @(posedge clk);
    {wr_en, rd_en, addr, page, wdata} <= {w, !w, a, p, d};
    @(posedge clk);
    {wr_en, rd_en} <= 2'b00;
    #1;
  endtask
  task automatic tally_and_finish;
    if (miscompares == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog, far beyond the 42 cycles of the sequence
  initial begin
    repeat (2000) @(posedge clk);
    miscompares++;
    tally_and_finish;
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    cmp("run", 8'h00, {2'b00, run});
    acc(0, 8'h95, 4'h1, 8'h00);
    cmp("start", 8'h00, rdata);
    acc(1, 8'h95, 4'h1, 8'h0f);
    cmp("run", 8'h0f, {2'b00, run});
    acc(0, 8'h96, 4'h1, 8'h00);
    cmp("status", 8'h0f, rdata);
    acc(0, 8'h95, 4'h1, 8'h00);
    cmp("start", 8'h00, rdata);
    acc(1, 8'h95, 4'h1, 8'h60);
    cmp("run", 8'h0f, {2'b00, run});
    @(posedge clk);
    mode <= 4'hc;
    acc(1, 8'h95, 4'h1, 8'h60);
    cmp("run", 8'h3f, {2'b00, run});
    acc(1, 8'h95, 4'h3, 8'h00);
    cmp("run", 8'h3f, {2'b00, run});
    acc(1, 8'h95, 4'h2, 8'h6f);
    cmp("reload", 8'h3f, {2'b00, reload_strobe});
    @(posedge clk);
    #1;
    cmp("reload", 8'h00, {2'b00, reload_strobe});
    @(posedge clk);
    mode <= 4'hf;
    acc(1, 8'h95, 4'h2, 8'h0f);
    cmp("reload", 8'h03, {2'b00, reload_strobe});
    acc(1, 8'h95, 4'h3, 8'h21);
    cmp("run", 8'h2e, {2'b00, run});
    @(posedge clk);
    mode <= 4'h0;
    acc(1, 8'h95, 4'h3, 8'h4e);
    cmp("run", 8'h20, {2'b00, run});
    // levels launched on an edge, taken on the next one
    @(posedge clk);
    run_sw_set <= 6'h02;
    run_sw_clr <= 6'h20;
    @(posedge clk);
    {run_sw_set, run_sw_clr} <= 12'h000;
    #1;
    cmp("run", 8'h02, {2'b00, run});
    acc(0, 8'h40, 4'h1, 8'h00);
    cmp("unmapped", 8'h00, rdata);
    tally_and_finish;
  end
endmodule // testbench
